// ---- hdl/ipr_port.sv ----
`include "ipr_map.svh"

// Function
// - works with bus clock up to 400 kHz
// - write is seven bytes: address, regaddr, data
// - every byte followed by acknowledge slot
// - single byte transactions change nothing
// - answer only to address 0110000, plus direction
// - data sampled on rising clock edge
// - acknowledge address only when it matches
// - first register byte is bits 15:8, acked
// - second register byte is bits 7:0, acked
// - data bytes least significant first, MSB-first bits
// - next byte only after previous acknowledge
// - device transmits and may drive the clock
// - start is data falling while clock high
// - read returns four bytes, LSB first
module ipr_port #(
   parameter logic [6:0] DEV_ADDR = `IPR_DEV_ADDR
) (
   input wire logic mclk, // system clock, 200 MHz
   input wire logic reset, // synchronous, active high
   input wire logic scl_in, // bus clock pin level
   output logic scl_out, // bus clock drive level
   output logic scl_oe_n, // low while holding the clock low
   input wire logic sda_in, // bus data pin level
   output logic sda_out, // bus data drive level
   output logic sda_oe_n, // low while pulling data low
   output logic wr_en, // one-cycle register write strobe
   output logic [15:0] wr_addr, // register address of the write
   output logic [31:0] wr_data, // register data of the write
   output logic rd_req, // one-cycle register read request
   output logic [15:0] rd_addr, // register address of the read
   input wire logic [31:0] rd_data, // read data, taken with rd_valid
   input wire logic rd_valid // read data ready, same clock
);

   // =============================================
   // elaboration checks
   localparam int SCL_LOW_CYC = `IPR_SCL_LOW_MIN_NS / `IPR_MCLK_PERIOD_NS;
   localparam int SCL_MIN_CYC = `IPR_MCLK_KHZ / `IPR_SCL_MAX_KHZ;

   // synchroniser delay must stay well inside the shortest clock low phase
   if (SCL_LOW_CYC <= 2 * `IPR_SYNC_LATENCY || SCL_MIN_CYC <= SCL_LOW_CYC) begin : g_rate_chk
      $error("bus clock too fast for the sampling clock");
   end
   if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_addr_chk
      $error("device address lies in a reserved range");
   end

   function automatic logic addr_hit(input logic [7:0] b);
      addr_hit = (b[7:1] == DEV_ADDR);
   endfunction : addr_hit

   ipr_pkg::ipr_regs_t r;
   ipr_pkg::ipr_regs_t next_r;

   // =============================================
   // bus events, from synchronised samples only
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise = r.scl_s2 & ~r.scl_d;
   assign scl_fall = ~r.scl_s2 & r.scl_d;
   assign start_det = r.scl_s2 & r.scl_d & ~r.sda_s2 & r.sda_d;
   assign stop_det = r.scl_s2 & r.scl_d & r.sda_s2 & ~r.sda_d;

   // end of an eight-bit byte, for the checks below
   logic byte_done;
   assign byte_done = scl_fall && r.bitcnt == `IPR_BYTE_BITS && !start_det && !stop_det;

   // =============================================
   // sequencer
   always_comb begin
      next_r = r;
      next_r.scl_s1 = scl_in;
      next_r.scl_s2 = r.scl_s1;
      next_r.scl_d = r.scl_s2;
      next_r.sda_s1 = sda_in;
      next_r.sda_s2 = r.sda_s1;
      next_r.sda_d = r.sda_s2;
      next_r.wr_en = 1'b0;
      next_r.rd_req = 1'b0;
      next_r.drv_lvl = 1'b0;
      if (stop_det) begin
         // unfinished writes die here
         next_r.st = ipr_pkg::IPR_IDLE;
         next_r.sda_oe_n = 1'b1;
         next_r.scl_oe_n = 1'b1;
      end else if (start_det) begin
         // repeated start keeps the register address
         next_r.st = ipr_pkg::IPR_ADDR;
         next_r.bitcnt = '0;
         next_r.bytecnt = '0;
         next_r.sda_oe_n = 1'b1;
         next_r.scl_oe_n = 1'b1;
      end else begin
         case (r.st)
            ipr_pkg::IPR_ADDR, ipr_pkg::IPR_RX: begin
               if (scl_rise && r.bitcnt != `IPR_BYTE_BITS) begin
                  next_r.shreg = {r.shreg[6:0], r.sda_s2};
                  next_r.bitcnt = r.bitcnt + 4'h1;
               end else if (scl_fall && r.bitcnt == `IPR_BYTE_BITS) begin
                  next_r.bitcnt = '0;
                  next_r.rd_next = 1'b0;
                  if (r.st == ipr_pkg::IPR_ADDR) begin
                     if (addr_hit(r.shreg)) begin
                        next_r.rd_next = (r.shreg[0] == `IPR_RW_READ);
                        next_r.sda_oe_n = 1'b0;
                        next_r.st = ipr_pkg::IPR_ACK;
                     end else begin
                        next_r.st = ipr_pkg::IPR_IDLE;
                     end
                  end else if (r.bytecnt < `IPR_REGADDR_BYTES) begin
                     next_r.reg_addr = {r.reg_addr[7:0], r.shreg};
                     next_r.bytecnt = r.bytecnt + 3'h1;
                     next_r.sda_oe_n = 1'b0;
                     next_r.st = ipr_pkg::IPR_ACK;
                  end else if (r.bytecnt <= `IPR_LAST_WR_BYTE) begin
                     // low byte arrives first and ends up in bits 7:0
                     next_r.wdata = {r.shreg, r.wdata[31:8]};
                     next_r.bytecnt = r.bytecnt + 3'h1;
                     next_r.wr_en = (r.bytecnt == `IPR_LAST_WR_BYTE);
                     next_r.sda_oe_n = 1'b0;
                     next_r.st = ipr_pkg::IPR_ACK;
                  end else begin
                     // bytes past the seventh are not acknowledged
                     next_r.st = ipr_pkg::IPR_IDLE;
                  end
               end
            end
            ipr_pkg::IPR_ACK: begin
               if (scl_fall) begin
                  next_r.sda_oe_n = 1'b1;
                  if (r.rd_next) begin
                     // hold the clock low until the register data is in hand
                     next_r.scl_oe_n = 1'b0;
                     next_r.rd_req = 1'b1;
                     next_r.st = ipr_pkg::IPR_WAIT;
                  end else begin
                     next_r.st = ipr_pkg::IPR_RX;
                  end
               end
            end
            ipr_pkg::IPR_WAIT: begin
               if (rd_valid) begin
                  next_r.shreg = rd_data[7:0];
                  next_r.rdata = {8'h00, rd_data[31:8]};
                  next_r.bytecnt = '0;
                  next_r.bitcnt = '0;
                  next_r.sda_oe_n = rd_data[7];
                  next_r.scl_oe_n = 1'b1;
                  next_r.st = ipr_pkg::IPR_TX;
               end
            end
            ipr_pkg::IPR_TX: begin
               if (scl_fall) begin
                  next_r.bitcnt = r.bitcnt + 4'h1;
                  if (r.bitcnt == `IPR_LAST_TX_BIT) begin
                     next_r.sda_oe_n = 1'b1;
                     next_r.st = ipr_pkg::IPR_TXACK;
                  end else begin
                     next_r.shreg = {r.shreg[6:0], 1'b0};
                     next_r.sda_oe_n = r.shreg[6];
                  end
               end
            end
            ipr_pkg::IPR_TXACK: begin
               if (scl_rise) begin
                  next_r.mack = ~r.sda_s2;
               end else if (scl_fall) begin
                  // a missing acknowledge ends our part of the read
                  if (r.mack && r.bytecnt != `IPR_LAST_RD_BYTE) begin
                     next_r.bytecnt = r.bytecnt + 3'h1;
                     next_r.shreg = r.rdata[7:0];
                     next_r.rdata = {8'h00, r.rdata[31:8]};
                     next_r.sda_oe_n = r.rdata[7];
                     next_r.bitcnt = '0;
                     next_r.st = ipr_pkg::IPR_TX;
                  end else begin
                     next_r.st = ipr_pkg::IPR_IDLE;
                  end
               end
            end
            default: begin
               next_r.sda_oe_n = 1'b1;
               next_r.scl_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         r <= '0;
         // sync stages start at the idle bus level, so reset leaves no false edge
         r.scl_s1 <= 1'b1;
         r.scl_s2 <= 1'b1;
         r.scl_d <= 1'b1;
         r.sda_s1 <= 1'b1;
         r.sda_s2 <= 1'b1;
         r.sda_d <= 1'b1;
         r.sda_oe_n <= 1'b1;
         r.scl_oe_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // =============================================
   // outputs
   assign scl_out = r.drv_lvl;
   assign sda_out = r.drv_lvl;
   assign scl_oe_n = r.scl_oe_n;
   assign sda_oe_n = r.sda_oe_n;
   assign wr_en = r.wr_en;
   assign wr_addr = r.reg_addr;
   assign wr_data = r.wdata;
   assign rd_req = r.rd_req;
   assign rd_addr = r.reg_addr;

   // =============================================
   // assertions
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);

   a_start_enters_addr: assert property (start_det && !stop_det |=> r.st == ipr_pkg::IPR_ADDR)
      else $error("start not followed by address phase");
   a_stop_goes_idle: assert property (stop_det |=> r.st == ipr_pkg::IPR_IDLE && sda_oe_n)
      else $error("stop did not end the transfer");
   a_stop_no_commit: assert property (stop_det |=> !wr_en)
      else $error("write committed at a stop");

   // =============================================
   // receive path checks
   a_ack_only_match: assert property (
      r.st == ipr_pkg::IPR_ADDR ##1 r.st == ipr_pkg::IPR_ACK |-> addr_hit(r.shreg))
      else $error("acknowledged a foreign address");
   a_addr_direction: assert property (
      r.st == ipr_pkg::IPR_ADDR && byte_done && addr_hit(r.shreg)
      |=> r.st == ipr_pkg::IPR_ACK && !sda_oe_n && r.rd_next == $past(r.shreg[0]))
      else $error("own address not acknowledged");
   a_foreign_no_ack: assert property (
      r.st == ipr_pkg::IPR_ADDR && byte_done && !addr_hit(r.shreg)
      |=> r.st == ipr_pkg::IPR_IDLE && sda_oe_n)
      else $error("foreign address acknowledged");
   a_ack_drives_low: assert property (r.st == ipr_pkg::IPR_ACK |-> !sda_oe_n)
      else $error("acknowledge slot not driven low");
   a_ack_released: assert property (r.st == ipr_pkg::IPR_ACK && scl_fall |=> sda_oe_n)
      else $error("acknowledge held past its clock");
   a_rise_samples_bit: assert property (
      scl_rise && !start_det && !stop_det && r.bitcnt != `IPR_BYTE_BITS
      && (r.st == ipr_pkg::IPR_ADDR || r.st == ipr_pkg::IPR_RX)
      |=> r.bitcnt == $past(r.bitcnt) + 4'h1 && r.shreg[0] == $past(r.sda_s2))
      else $error("bit not sampled on rising clock");
   a_bitcnt_bound: assert property (r.bitcnt <= `IPR_BYTE_BITS)
      else $error("bit counter ran past a byte");
   a_regaddr_order: assert property (
      r.st == ipr_pkg::IPR_RX && byte_done && r.bytecnt < `IPR_REGADDR_BYTES
      |=> r.reg_addr == {$past(r.reg_addr[7:0]), $past(r.shreg)})
      else $error("register address bytes out of order");
   a_data_lsb_first: assert property (
      r.st == ipr_pkg::IPR_RX && byte_done && r.bytecnt >= `IPR_REGADDR_BYTES && r.bytecnt <= `IPR_LAST_WR_BYTE
      |=> r.wdata[31:24] == $past(r.shreg))
      else $error("data byte not taken in at the top");
   a_extra_byte_nack: assert property (
      r.st == ipr_pkg::IPR_RX && byte_done && r.bytecnt > `IPR_LAST_WR_BYTE
      |=> r.st == ipr_pkg::IPR_IDLE && sda_oe_n && !wr_en)
      else $error("byte past the seventh was acknowledged");
   a_write_full_frame: assert property (
      wr_en |-> r.st == ipr_pkg::IPR_ACK && r.bytecnt == `IPR_LAST_WR_BYTE + 3'h1)
      else $error("write committed before seventh byte");

   // =============================================
   // transmit path checks
   a_fetch_request: assert property (
      r.st == ipr_pkg::IPR_ACK && r.rd_next && scl_fall
      |=> rd_req && !scl_oe_n && r.st == ipr_pkg::IPR_WAIT)
      else $error("read address acknowledged but no fetch");
   a_read_holds_clock: assert property (rd_req || r.st == ipr_pkg::IPR_WAIT |-> !scl_oe_n)
      else $error("clock not held during register fetch");
   a_fetch_releases: assert property (
      r.st == ipr_pkg::IPR_WAIT && rd_valid && !start_det && !stop_det
      |=> scl_oe_n && r.st == ipr_pkg::IPR_TX && r.shreg == $past(rd_data[7:0]))
      else $error("fetch did not start transmission");
   a_tx_bit_level: assert property (r.st == ipr_pkg::IPR_TX |-> sda_oe_n == r.shreg[7])
      else $error("transmitted bit differs from shift register");
   a_txack_released: assert property (r.st == ipr_pkg::IPR_TXACK |-> sda_oe_n)
      else $error("data line held in master acknowledge slot");
   a_nack_ends_read: assert property (
      r.st == ipr_pkg::IPR_TXACK && scl_fall && !r.mack
      |=> r.st == ipr_pkg::IPR_IDLE && sda_oe_n)
      else $error("sent on after a missing acknowledge");

   c_write_done: cover property (wr_en);
   c_read_fetch: cover property (rd_req ##[1:20] rd_valid);
   c_repeated_start: cover property (r.st == ipr_pkg::IPR_RX && start_det);
   c_read_last_byte: cover property (r.st == ipr_pkg::IPR_TXACK && r.bytecnt == `IPR_LAST_RD_BYTE);
   c_extra_byte: cover property (r.st == ipr_pkg::IPR_RX && byte_done && r.bytecnt > `IPR_LAST_WR_BYTE);

endmodule : ipr_port

// ---- hdl/ipr_map.svh ----
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

// =============================================
// bus addressing
`define IPR_DEV_ADDR 7'h30
`define IPR_RW_READ 1'b1

// =============================================
// frame layout, byte indices counted after the address byte
`define IPR_BYTE_BITS 4'h8
`define IPR_LAST_TX_BIT 4'h7
`define IPR_REGADDR_BYTES 3'h2
`define IPR_LAST_WR_BYTE 3'h5
`define IPR_LAST_RD_BYTE 3'h3

// =============================================
// timing
`define IPR_MCLK_KHZ 200000
`define IPR_SCL_MAX_KHZ 400
`define IPR_SCL_LOW_MIN_NS 1300
`define IPR_MCLK_PERIOD_NS 5
`define IPR_SYNC_LATENCY 3

`endif

// ---- hdl/ipr_pkg.sv ----
package ipr_pkg;

   // =============================================
   // port sequencer states
   typedef enum logic [2:0] {
      IPR_IDLE,
      IPR_ADDR,
      IPR_RX,
      IPR_ACK,
      IPR_WAIT,
      IPR_TX,
      IPR_TXACK
   } ipr_state_t;

   // =============================================
   // complete state of the port
   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_d;
      logic sda_s1;
      logic sda_s2;
      logic sda_d;
      ipr_state_t st;
      logic [3:0] bitcnt;
      logic [7:0] shreg;
      logic [2:0] bytecnt;
      logic rd_next;
      logic mack;
      logic [15:0] reg_addr;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic wr_en;
      logic rd_req;
      logic sda_oe_n;
      logic scl_oe_n;
      logic drv_lvl;
   } ipr_regs_t;

endpackage : ipr_pkg

// ---- tb/ipr_master_model.sv ----
// ==========================================
// bus master model; 1 on a drive means released
module ipr_master_model (
   input wire logic mclk, // system clock
   input wire logic scl_w, // resolved bus clock
   input wire logic sda_w, // resolved bus data
   output logic scl_m, // master clock drive
   output logic sda_m // master data drive
);
   timeunit 1ns;
   timeprecision 1ps;
   int n_stuck = 0;
   initial begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   task automatic half();
      repeat (8) @(negedge mclk);
   endtask : half
   task automatic clock_low();
      scl_m = 1'b0;
      half();
   endtask : clock_low
   // the port holds the clock low while it fetches read data
   task automatic rise();
      int n;
      scl_m = 1'b1;
      n = 0;
      while (scl_w !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 400) begin
         n_stuck++;
      end
      half();
   endtask : rise
   task automatic start();
      sda_m = 1'b1;
      half();
      rise();
      sda_m = 1'b0;
      half();
      scl_m = 1'b0;
   endtask : start
   task automatic stop();
      sda_m = 1'b0;
      half();
      rise();
      sda_m = 1'b1;
      half();
   endtask : stop
   // data moves only while the clock is low
   task automatic put(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_m = b[i];
         half();
         rise();
         scl_m = 1'b0;
      end
      sda_m = 1'b1;
      half();
      rise();
      ack = sda_w;
      scl_m = 1'b0;
   endtask : put
   task automatic get(input logic nack, output logic [7:0] b);
      sda_m = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         half();
         rise();
         b[i] = sda_w;
         scl_m = 1'b0;
      end
      sda_m = nack;
      half();
      rise();
      scl_m = 1'b0;
   endtask : get
endmodule : ipr_master_model

// ---- tb/test_i2c_paged_register_port.sv ----
module test_i2c_paged_register_port;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] RD_VAL = 32'h1357_9bdf;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic rd_valid = 1'b0;
   logic [31:0] rd_data = 32'h0000_0000;
   logic scl_m, sda_m, scl_oe_n, sda_oe_n, scl_o, sda_o, wr_en, rd_req, a;
   logic [15:0] wr_addr, rd_addr, last_a, rd_a;
   logic [31:0] wr_data, last_d, got;
   logic [7:0] b;
   logic [6:0] ak;
   int n_errors = 0;
   int checks_done = 0;
   int n_wr = 0;
   int n0;
   // the port pulls to its drive level only while its enable is low
   wire scl_w = scl_m & (scl_oe_n | scl_o);
   wire sda_w = sda_m & (sda_oe_n | sda_o);

   // ==========================================
   // clock, design and master
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   ipr_port ipr_port_inst (.mclk(mclk), .reset(reset), .scl_in(scl_w), .scl_out(scl_o), .scl_oe_n(scl_oe_n),
      .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n(sda_oe_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
   ipr_master_model ipr_master_model_inst (.mclk(mclk), .scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
      .sda_m(sda_m));

   // ==========================================
   // register side: log writes, answer fetches on the next falling edge
   always @(negedge mclk) begin
      if (wr_en === 1'b1) begin
         n_wr++;
         last_a = wr_addr;
         last_d = wr_data;
      end
      rd_valid <= 1'b0;
      rd_data <= ~RD_VAL;
      if (rd_req === 1'b1) begin
         rd_valid <= 1'b1;
         rd_data <= RD_VAL;
         rd_a <= rd_addr;
      end
   end

   // ==========================================
   // shared tasks
   task automatic check(input logic [31:0] exp, input logic [31:0] got_v);
      checks_done++;
      if (got_v !== exp) begin
         n_errors++;
         $display("Error at %0t ns: expected %h, got %h", $time, exp, got_v);
      end
   endtask : check
   task automatic frame(input logic [7:0] dev, input logic [15:0] ra, input logic [31:0] d, input int n);
      logic [55:0] fr;
      fr = {dev, ra, d[7:0], d[15:8], d[23:16], d[31:24]};
      ak = 7'h7f;
      ipr_master_model_inst.start();
      for (int i = 0; i < n; i++) begin
         ipr_master_model_inst.put(fr[55-8*i -: 8], ak[6-i]);
      end
   endtask : frame

   // ==========================================
   // scenarios
   task automatic t_write();
      n0 = n_wr;
      frame(8'h60, 16'h0521, 32'ha5c3_1e07, 7);
      ipr_master_model_inst.put(8'h5a, a);
      ipr_master_model_inst.stop();
      check(32'h0000_0000, {25'h0, ak});
      check(32'h0000_0001, {31'h0, a});
      check(n0 + 1, n_wr);
      check({16'h0000, 16'h0521}, {16'h0000, last_a});
      check(32'ha5c3_1e07, last_d);
   endtask : t_write
   task automatic t_short();
      n0 = n_wr;
      frame(8'h60, 16'h0522, 32'h0bad_f00d, 5);
      ipr_master_model_inst.stop();
      frame(8'h60, 16'h0000, 32'h0000_0000, 1);
      ipr_master_model_inst.stop();
      check(n0, n_wr);
   endtask : t_short
   task automatic t_wrong();
      n0 = n_wr;
      ipr_master_model_inst.clock_low();
      ipr_master_model_inst.put(8'h60, a);
      ipr_master_model_inst.stop();
      check(32'h0000_0001, {31'h0, a});
      frame(8'h62, 16'h0521, 32'h1111_2222, 7);
      ipr_master_model_inst.stop();
      check(32'h0000_0001, {31'h0, ak[6]});
      check(n0, n_wr);
   endtask : t_wrong
   task automatic t_read();
      frame(8'h60, 16'h0510, 32'h0000_0000, 3);
      ipr_master_model_inst.start();
      ipr_master_model_inst.put(8'h61, a);
      check(32'h0000_0000, {28'h0, ak[6:4], a});
      for (int i = 0; i < 4; i++) begin
         ipr_master_model_inst.get(i == 3, b);
         got[8*i +: 8] = b;
      end
      ipr_master_model_inst.stop();
      check(RD_VAL, got);
      check({16'h0000, 16'h0510}, {16'h0000, rd_a});
   endtask : t_read

   // ==========================================
   // verdict, main sequence, watchdog
   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      t_write();
      t_short();
      t_wrong();
      t_read();
      check(32'h0000_0000, ipr_master_model_inst.n_stuck);
      report_and_stop();
   end
   // whole run is about 30 bytes of some 150 cycles each
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end
endmodule : test_i2c_paged_register_port
